// *** reset_seq_pkg.sv ***
// constants shared by the reset cause and start-up delay block
package reset_seq_pkg;

	// start-up delay in system clock pulses
	localparam int unsigned STARTUP_CLOCKS = 1024;
	// option-load delay in system clock pulses (length not fixed by the part)
	localparam int unsigned OPTION_LOAD_CLOCKS = 16;
	localparam int unsigned DELAY_W = 11;
	localparam logic [DELAY_W-1:0] STARTUP_COUNT = DELAY_W'(STARTUP_CLOCKS - 1);
	localparam logic [DELAY_W-1:0] OPTION_COUNT = DELAY_W'(OPTION_LOAD_CLOCKS - 1);

	// reset values driven to the rest of the chip
	localparam logic [11:0] PC_RESET = 12'h000;
	localparam logic [2:0] SP_TOP = 3'h7;

	// reset kind applied to the functional units
	typedef enum logic [1:0] {
		KIND_NONE = 2'h0,
		KIND_FULL = 2'h1,
		KIND_WARM = 2'h2
	} reset_kind_t;

	// sequencer states, gray along run -> option -> startup; startup -> run changes both bits
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_OPTION = 2'b01,
		ST_STARTUP = 2'b11
	} seq_state_t;

endpackage : reset_seq_pkg

// *** reset_cause_and_startup_delay.sv ***
// reset source decode, cause flags and start-up delay sequencer
`timescale 1ns/1ps

// Notes on behaviour
// - pin reset or normal watchdog timeout starts reset
// - halted watchdog timeout resets only pc, sp
// - retained registers depend on reset source kind
// - full reset loads defined initial values
// - both cause flags stay readable for software
// - power-up leaves both flags zero
// - normal pin reset keeps both flags
// - normal watchdog timeout sets timeout, keeps powerdown
// - startup timer holds 1024 clocks in reset
// - every halt wake-up runs startup delay
// - system reset adds option-load delay too
// - chip reset: pc zero, units off, sp top
// - powerdown cleared by power-up/clear, set by halt
// - halt sets powerdown and clears timeout
module reset_cause_and_startup_delay
	import reset_seq_pkg::*;
(
	input wire logic clk, // 40 MHz system clock
	input wire logic rst_b, // power-up reset, async, active low
	input wire logic ext_reset_pin_n, // external reset pin, active low, async
	input wire logic wdt_timeout, // watchdog overflow pulse, same clock
	input wire logic halt_exec, // halt instruction executing, pulse
	input wire logic clr_wdt_exec, // watchdog-clear instruction, pulse
	input wire logic wake_other, // port or interrupt wake while halted, pulse
	output logic timeout_flag, // reset cause: watchdog timeout
	output logic powerdown_flag, // reset cause: halt was entered
	output logic halted, // device is in halt
	output logic cpu_hold, // execution held during delays
	output logic full_reset, // functional units held in reset state
	output logic warm_reset, // pulse: clear pc and sp only
	output logic unit_reset_pulse, // pulse: full reset accepted
	output logic [11:0] pc_reset_value, // program counter load value
	output logic [2:0] sp_reset_value, // stack pointer load value
	output logic irq_disable, // interrupts held disabled
	output logic prescaler_clear, // prescalers and watchdog cleared
	output logic timers_off, // timers and pulse_gen stopped
	output logic pulse_gen_float, // pulse_gen outputs floating
	output logic ports_input // ports forced to input mode
);

	logic pin_meta; // first synchroniser stage
	logic pin_sync; // pin level, active low, synchronised
	logic pin_prev; // previous synced level for edge detect
	logic pin_fall; // new assertion of the pin
	logic ev_pin_norm; // pin reset in normal operation
	logic ev_pin_halt; // pin reset waking halt
	logic ev_wdt_norm; // watchdog reset in normal operation
	logic ev_wdt_halt; // watchdog wake from halt
	logic ev_wake; // any wake from halt
	logic ev_system; // any full system reset
	seq_state_t state; // sequencer state
	logic [DELAY_W-1:0] count; // delay counter
	logic por_pending; // power-up still needs its delays

	// two-stage synchroniser, the pin is asynchronous
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_meta <= 1'b1;
			pin_sync <= 1'b1;
			pin_prev <= 1'b1;
		end else begin
			pin_meta <= ext_reset_pin_n;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// event decode, halt state splits the sources
	always_comb begin
		pin_fall = pin_prev && !pin_sync;
		ev_pin_norm = pin_fall && !halted;
		ev_pin_halt = pin_fall && halted;
		ev_wdt_norm = wdt_timeout && !halted && !cpu_hold;
		ev_wdt_halt = wdt_timeout && halted && !pin_fall;
		ev_wake = ev_pin_halt || ev_wdt_halt || (wake_other && halted);
		ev_system = ev_pin_norm || ev_pin_halt || ev_wdt_norm;
	end

	// halt tracking; any wake leaves halt
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			halted <= 1'b0;
		end else if (ev_wake || ev_system) begin
			halted <= 1'b0;
		end else if (halt_exec && !cpu_hold) begin
			halted <= 1'b1;
		end
	end

	// timeout flag; reset events win over instruction effects
	// both cause flags are plain outputs so software can read them
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			timeout_flag <= 1'b0;
		end else if (ev_wdt_norm || ev_wdt_halt) begin
			timeout_flag <= 1'b1;
		end else if (ev_pin_halt) begin
			timeout_flag <= 1'b0;
		end else if (ev_pin_norm) begin
			timeout_flag <= timeout_flag;
		end else if (halt_exec && !cpu_hold) begin
			timeout_flag <= 1'b0;
		end else if (clr_wdt_exec && !cpu_hold) begin
			timeout_flag <= 1'b0; // clear-watchdog also clears timeout
		end
	end

	// powerdown flag; set by halt, cleared by power-up or watchdog clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			powerdown_flag <= 1'b0;
		end else if (ev_pin_halt || ev_wdt_halt) begin
			powerdown_flag <= 1'b1;
		end else if (ev_pin_norm || ev_wdt_norm) begin
			powerdown_flag <= powerdown_flag;
		end else if (halt_exec && !cpu_hold) begin
			powerdown_flag <= 1'b1;
		end else if (clr_wdt_exec && !cpu_hold) begin
			powerdown_flag <= 1'b0;
		end
	end

	// delay sequencer: option load then start-up, or start-up alone on watchdog or other halt wake
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_RUN;
			count <= '0;
			por_pending <= 1'b1;
		end else if (ev_system || por_pending || !pin_sync) begin
			// pin held low restarts the delays, so they run after release
			state <= ST_OPTION;
			count <= OPTION_COUNT;
			por_pending <= 1'b0;
		end else if (ev_wake) begin
			state <= ST_STARTUP;
			count <= STARTUP_COUNT;
		end else begin
			unique case (state)
				ST_RUN: begin
					count <= '0;
				end
				ST_OPTION: begin
					if (count == '0) begin
						state <= ST_STARTUP;
						count <= STARTUP_COUNT;
					end else begin
						count <= count - 1'b1;
					end
				end
				ST_STARTUP: begin
					if (count == '0) begin
						state <= ST_RUN;
					end else begin
						count <= count - 1'b1;
					end
				end
				default: begin
					state <= ST_RUN; // unused code recovers to run
				end
			endcase
		end
	end

	// execution hold and full reset level; pin held low keeps reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cpu_hold <= 1'b1;
			full_reset <= 1'b1;
		end else begin
			cpu_hold <= ev_system || ev_wake || por_pending || (state != ST_RUN
				&& !(state == ST_STARTUP && count == '0)) || !pin_sync;
			// warm wake keeps units untouched, so only system resets hold them
			if (ev_system || por_pending || !pin_sync) begin
				full_reset <= 1'b1;
			end else if (state == ST_RUN || ev_wake || (state == ST_STARTUP
				&& count == '0)) begin
				full_reset <= 1'b0;
			end
		end
	end

	// one-cycle reset kind strobes for the core
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			warm_reset <= 1'b0;
			unit_reset_pulse <= 1'b0;
		end else begin
			warm_reset <= ev_wdt_halt;
			unit_reset_pulse <= ev_system;
		end
	end

	// unit reset states follow the full reset level
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_disable <= 1'b1;
			prescaler_clear <= 1'b1;
			timers_off <= 1'b1;
			pulse_gen_float <= 1'b1;
			ports_input <= 1'b1;
		end else begin
			irq_disable <= full_reset;
			// watchdog counts again once the full reset drops
			prescaler_clear <= full_reset;
			timers_off <= full_reset;
			pulse_gen_float <= full_reset;
			ports_input <= full_reset;
		end
	end

	// load values are constant; kept in flops so outputs are registered
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pc_reset_value <= PC_RESET;
			sp_reset_value <= SP_TOP;
		end else begin
			pc_reset_value <= PC_RESET;
			sp_reset_value <= SP_TOP;
		end
	end

endmodule : reset_cause_and_startup_delay

// *** reset_seq_properties.sv ***
// checker for reset cause flags and start-up delay
`timescale 1ns/1ps
module reset_seq_properties (
	input wire logic clk, // system clock
	input wire logic rst_b, // power-up reset
	input wire logic ext_reset_pin_n, // pin
	input wire logic wdt_timeout, // watchdog pulse
	input wire logic halt_exec, // halt pulse
	input wire logic timeout_flag, // cause flag
	input wire logic powerdown_flag, // cause flag
	input wire logic halted, // in halt
	input wire logic cpu_hold, // hold
	input wire logic full_reset, // units reset
	input wire logic warm_reset, // warm pulse
	input wire logic unit_reset_pulse, // full pulse
	input wire logic [11:0] pc_reset_value, // pc load
	input wire logic [2:0] sp_reset_value, // sp load
	input wire logic ports_input // ports as input
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_pc; pc_reset_value == 12'h000 && sp_reset_value == 3'h7; endproperty
	a_pc: assert property (p_pc) else $error("bad pc or sp value");
	property p_halt; !cpu_hold && halt_exec |=> halted && powerdown_flag && !timeout_flag;
	endproperty
	a_halt: assert property (p_halt) else $error("halt flags wrong");
	property p_warm; halted && wdt_timeout |=> warm_reset && timeout_flag && powerdown_flag;
	endproperty
	a_warm: assert property (p_warm) else $error("warm wake wrong");
	property p_wfull; !halted && !cpu_hold && wdt_timeout |=>
		unit_reset_pulse && timeout_flag && $stable(powerdown_flag); endproperty
	a_wfull: assert property (p_wfull) else $error("watchdog reset wrong");
	property p_wkeep; warm_reset |-> !full_reset; endproperty
	a_wkeep: assert property (p_wkeep) else $error("warm reset hit units");
	property p_delay; $rose(warm_reset) |-> cpu_hold [*8]; endproperty
	a_delay: assert property (p_delay) else $error("no start-up delay");
	property p_pin; $fell(ext_reset_pin_n) |-> ##[1:4] unit_reset_pulse; endproperty
	a_pin: assert property (p_pin) else $error("pin reset missed");
	property p_units; full_reset |=> ports_input; endproperty
	a_units: assert property (p_units) else $error("ports not input");
	c_warm: cover property (warm_reset);
	c_full: cover property (unit_reset_pulse);
	c_run: cover property ($fell(cpu_hold));
endmodule : reset_seq_properties
bind reset_cause_and_startup_delay reset_seq_properties chk (.clk(clk), .rst_b(rst_b),
	.ext_reset_pin_n(ext_reset_pin_n), .wdt_timeout(wdt_timeout), .halt_exec(halt_exec),
	.timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .halted(halted),
	.cpu_hold(cpu_hold), .full_reset(full_reset), .warm_reset(warm_reset),
	.unit_reset_pulse(unit_reset_pulse), .pc_reset_value(pc_reset_value),
	.sp_reset_value(sp_reset_value), .ports_input(ports_input));

// *** reset_source_model.sv ***
// external reset pin and watchdog stand-in
`timescale 1ns/1ps
module reset_source_model (
	input wire logic clk, // system clock
	output logic ext_reset_pin_n, // pulled-up reset pin
	output logic wdt_timeout // watchdog overflow pulse
);
	initial begin
		ext_reset_pin_n = 1'b1;
		wdt_timeout = 1'b0;
	end
	// one overflow pulse
	task automatic wdt_fire();
		@(posedge clk) wdt_timeout <= 1'b1;
		@(posedge clk) wdt_timeout <= 1'b0;
		#1;
	endtask : wdt_fire
	// pin held low for n cycles, then back to pull-up level
	task automatic pin_low(input int n);
		@(posedge clk) ext_reset_pin_n <= 1'b0;
		repeat (n) @(posedge clk);
		ext_reset_pin_n <= 1'b1;
		#1;
	endtask : pin_low
endmodule : reset_source_model

// *** test_reset_cause_and_startup_delay.sv ***
// self-checking bench for reset cause flags and start-up delay
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
	$display("unexpected t=%0t got %h exp %h", $time, (a), (b)); end end
module test_reset_cause_and_startup_delay;
	logic clk = 0, rst_b = 0, halt_exec = 0, clr_wdt_exec = 0, wake_other = 0;
	logic ext_reset_pin_n, wdt_timeout, timeout_flag, powerdown_flag, halted;
	logic cpu_hold, full_reset, warm_reset;
	int n_mismatch = 0, samples_checked = 0;
	always #12.5 clk = ~clk;
	reset_source_model src (.clk(clk), .ext_reset_pin_n(ext_reset_pin_n),
		.wdt_timeout(wdt_timeout));
	reset_cause_and_startup_delay dut (.clk(clk), .rst_b(rst_b),
		.ext_reset_pin_n(ext_reset_pin_n), .wdt_timeout(wdt_timeout), .halt_exec(halt_exec),
		.clr_wdt_exec(clr_wdt_exec), .wake_other(wake_other), .timeout_flag(timeout_flag),
		.powerdown_flag(powerdown_flag), .halted(halted), .cpu_hold(cpu_hold),
		.full_reset(full_reset), .warm_reset(warm_reset), .unit_reset_pulse(),
		.pc_reset_value(), .sp_reset_value(), .irq_disable(), .prescaler_clear(),
		.timers_off(), .pulse_gen_float(), .ports_input());
	// one-cycle instruction pulse: 0 halt, 1 clear, else other wake
	task automatic pulse(input int k);
		@(posedge clk);
		if (k == 0) halt_exec <= 1'b1;
		else if (k == 1) clr_wdt_exec <= 1'b1;
		else wake_other <= 1'b1;
		@(posedge clk) {halt_exec, clr_wdt_exec, wake_other} <= 3'h0;
		#1;
	endtask : pulse
	// cycles spent in hold must land in [lo, hi]
	task automatic hold_len(input int lo, input int hi);
		int n;
		n = 0;
		while (cpu_hold === 1'b1 && n < 5000) begin
			@(posedge clk);
			#1;
			n++;
		end
		`CHK(n >= lo && n <= hi, 1'b1)
	endtask : hold_len
	task automatic flags(input logic t, input logic p);
		`CHK({timeout_flag, powerdown_flag}, {t, p})
	endtask : flags
	task automatic give_verdict();
		$display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	initial begin
		#300000;
		n_mismatch++;
		give_verdict();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		flags(0, 0);
		hold_len(1040, 1046);
		`CHK(full_reset, 1'b0)
		src.wdt_fire();
		flags(1, 0);
		hold_len(1040, 1046);
		pulse(0);
		flags(0, 1);
		src.wdt_fire();
		`CHK({warm_reset, full_reset}, 2'h2)
		flags(1, 1);
		hold_len(1023, 1026);
		pulse(0);
		src.pin_low(6);
		flags(0, 1);
		`CHK(full_reset, 1'b1)
		hold_len(1040, 1050);
		src.pin_low(6);
		hold_len(1040, 1050);
		flags(0, 1);
		pulse(1);
		flags(0, 0);
		pulse(0);
		pulse(2);
		`CHK(halted, 1'b0)
		hold_len(1023, 1026);
		give_verdict();
	end
endmodule : test_reset_cause_and_startup_delay
